// [rtl/out_endpoint_descriptor.v]
// output endpoint descriptor blocks for endpoints 1 to 3 and their OUT packet engine
`timescale 1ns/1ps
`default_nettype none
`include "out_ep_regs.vh"
module out_endpoint_descriptor #(
  parameter NUM_EP = 3
) (
  input  wire        i_core_clk,
  input  wire        i_srst,
  input  wire [15:0] i_xaddr,
  input  wire        i_xwr,
  input  wire        i_xrd,
  input  wire [7:0]  i_xwdata,
  output reg  [7:0]  o_xrdata,
  input  wire        i_tok_valid,
  input  wire [1:0]  i_tok_ep,
  input  wire        i_tok_data1,
  input  wire        i_rx_valid,
  input  wire [7:0]  i_rx_byte,
  output wire        o_rx_ready,
  input  wire        i_pkt_end,
  input  wire        i_pkt_good,
  output wire        o_ram_we,
  output wire [10:0] o_ram_addr,
  output wire [7:0]  o_ram_wdata,
  input  wire        i_ram_ready,
  output reg         o_hs_valid,
  output reg  [1:0]  o_hs_code,
  output reg  [2:0]  o_irq
);
  localparam S_IDLE = 3'b001;
  localparam S_DATA = 3'b010;
  localparam S_DONE = 3'b100;

  reg  [2:0]  state_q;
  reg  [1:0]  ep_q;
  reg         sel_y_q;
  reg         store_q;
  reg         dup_q;
  reg  [1:0]  code_q;
  reg  [6:0]  len_q;
  reg  [10:0] start_q;
  wire [23:0] cfg_all;
  wire [23:0] xb_all;
  wire [23:0] xc_all;
  wire [23:0] yb_all;
  wire [23:0] yc_all;
  wire        fifo_ready;
  wire        fifo_empty;

  // cpu side decode of the descriptor window
  wire        in_edb  = (i_xaddr[15:5] == `EDB_REGION_TAG) && (i_xaddr[4:3] != 2'b00);
  wire [1:0]  cpu_idx = i_xaddr[4:3] - 2'd1;
  wire [2:0]  entry   = i_xaddr[2:0];
  wire [1:0]  tok_idx = i_tok_ep - 2'd1;
  wire [7:0]  tok_cfg = cfg_all[8*tok_idx +: 8];
  wire [7:0]  tok_xc  = xc_all[8*tok_idx +: 8];
  wire [7:0]  tok_yc  = yc_all[8*tok_idx +: 8];
  wire        commit  = (state_q == S_DONE) && fifo_empty;
  wire        tok_y   = tok_cfg[`CFG_DOUBLE_BUFFER_ENABLE_BIT] & tok_cfg[`CFG_TOGGLE_BIT];
  wire        tok_dup = i_tok_data1 != tok_cfg[`CFG_TOGGLE_BIT];
  wire        tok_nak = tok_y ? tok_yc[`CNT_NAK_BIT] : tok_xc[`CNT_NAK_BIT];
  wire [7:0]  tok_base = tok_y ? yb_all[8*tok_idx +: 8] : xb_all[8*tok_idx +: 8];
  wire        store_byte = (state_q == S_DATA) && store_q && i_rx_valid && fifo_ready && (len_q < `CNT_MAX_BYTES);
  wire [10:0] byte_addr = start_q + {4'h0, len_q};

  // per endpoint descriptor entries
  genvar g;
  generate
    for (g = 0; g < NUM_EP; g = g + 1)
    begin : g_ep
      reg  [7:0] cfg_q;
      reg  [7:0] xb_q;
      reg  [7:0] xc_q;
      reg  [7:0] yb_q;
      reg  [7:0] yc_q;
      wire       wr_me  = i_xwr && in_edb && (cpu_idx == g);
      wire       hw_me  = commit && (ep_q == g);
      // cpu write first, the hardware update after it so a set wins
      always @(posedge i_core_clk)
      begin
        if (i_srst)
        begin
          cfg_q <= `CFG_RESET;
          xb_q  <= `ENTRY_RESET;
          xc_q  <= `ENTRY_RESET;
          yb_q  <= `ENTRY_RESET;
          yc_q  <= `ENTRY_RESET;
        end
        else
        begin
          if (wr_me && entry == `EDB_OFS_CFG)
            cfg_q <= i_xwdata & `CFG_RSV_MASK;
          if (wr_me && entry == `EDB_OFS_XBASE)
            xb_q <= i_xwdata;
          if (wr_me && entry == `EDB_OFS_XCOUNT)
            xc_q <= i_xwdata;
          if (wr_me && entry == `EDB_OFS_YBASE)
            yb_q <= i_xwdata;
          if (wr_me && entry == `EDB_OFS_YCOUNT)
            yc_q <= i_xwdata;
          // base entries are never touched here
          if (hw_me)
          begin
            cfg_q[`CFG_TOGGLE_BIT] <= ~cfg_q[`CFG_TOGGLE_BIT];
            if (sel_y_q)
              yc_q <= {1'b1, len_q};
            else
              xc_q <= {1'b1, len_q};
          end
        end
      end
      assign cfg_all[8*g +: 8] = cfg_q;
      assign xb_all[8*g +: 8]  = xb_q;
      assign xc_all[8*g +: 8]  = xc_q;
      assign yb_all[8*g +: 8]  = yb_q;
      assign yc_all[8*g +: 8]  = yc_q;
    end
  endgenerate

  // registered read port; holes and unmapped addresses read zero
  always @(posedge i_core_clk)
  begin
    if (i_srst)
      o_xrdata <= 8'h00;
    else if (i_xrd)
    begin
      if (!in_edb)
        o_xrdata <= 8'h00;
      else
        case (entry)
          `EDB_OFS_CFG:    o_xrdata <= cfg_all[8*cpu_idx +: 8];
          `EDB_OFS_XBASE:  o_xrdata <= xb_all[8*cpu_idx +: 8];
          `EDB_OFS_XCOUNT: o_xrdata <= xc_all[8*cpu_idx +: 8];
          `EDB_OFS_YBASE:  o_xrdata <= yb_all[8*cpu_idx +: 8];
          `EDB_OFS_YCOUNT: o_xrdata <= yc_all[8*cpu_idx +: 8];
          default:         o_xrdata <= 8'h00;
        endcase
    end
  end

  // packet engine: token, payload, handshake
  always @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      state_q    <= S_IDLE;
      ep_q       <= 2'd0;
      sel_y_q    <= 1'b0;
      store_q    <= 1'b0;
      dup_q      <= 1'b0;
      code_q     <= `HS_ACK;
      len_q      <= 7'd0;
      start_q    <= 11'd0;
      o_hs_valid <= 1'b0;
      o_hs_code  <= 2'd0;
      o_irq      <= 3'b000;
    end
    else
    begin
      o_hs_valid <= 1'b0;
      o_irq      <= 3'b000;
      case (state_q)
        S_IDLE:
        begin
          // a disabled endpoint gets no answer at all
          if (i_tok_valid && i_tok_ep != 2'd0 && tok_cfg[`CFG_BME_BIT])
          begin
            state_q <= S_DATA;
            ep_q    <= tok_idx;
            sel_y_q <= tok_y;
            start_q <= {tok_base, 3'b000};
            len_q   <= 7'd0;
            dup_q   <= tok_dup;
            store_q <= !tok_cfg[`CFG_STALL_BIT] && !tok_nak && !tok_dup;
            if (tok_cfg[`CFG_STALL_BIT])
              code_q <= `HS_STALL;
            else if (tok_nak)
              code_q <= `HS_NAK;
            else
              code_q <= `HS_ACK;
          end
        end
        S_DATA:
        begin
          if (store_byte)
            len_q <= len_q + 7'd1;
          if (i_pkt_end)
          begin
            // corrupt packets get no handshake, the host retries
            if (store_q && i_pkt_good)
              state_q <= S_DONE;
            else
            begin
              state_q    <= S_IDLE;
              o_hs_valid <= i_pkt_good;
              o_hs_code  <= code_q;
            end
          end
        end
        S_DONE:
        begin
          // wait for the last byte to reach ram before the count shows
          if (fifo_empty)
          begin
            state_q    <= S_IDLE;
            o_hs_valid <= 1'b1;
            o_hs_code  <= `HS_ACK;
            o_irq[ep_q] <= cfg_all[8*ep_q + `CFG_IRQ_EN_BIT];
          end
        end
        default:
          state_q <= S_IDLE;
      endcase
    end
  end

  pair_buffer #(
    .WIDTH (19)
  ) u_buf (
    .i_core_clk  (i_core_clk),
    .i_srst      (i_srst),
    .i_in_valid  (store_byte),
    .i_in_data   ({byte_addr, i_rx_byte}),
    .o_in_ready  (fifo_ready),
    .o_out_valid (o_ram_we),
    .o_out_data  ({o_ram_addr, o_ram_wdata}),
    .i_out_ready (i_ram_ready),
    .o_empty     (fifo_empty)
  );

  // bytes past 64 or for a refused packet are drained and dropped
  assign o_rx_ready = fifo_ready;
endmodule // out_endpoint_descriptor
`default_nettype wire

// [rtl/out_ep_regs.vh]
// constants for the output endpoint descriptor block
// Operation
// - A set completion interrupt enable makes a finished transaction raise an interrupt; a clear one raises none.
// - The stall bit resets to zero, makes the endpoint answer STALL while set, and only firmware clears it.
// - Without double buffering only the X buffer is used; with it the data toggle picks X or Y.
// - The data toggle bit follows the DATA0/DATA1 sequence of the endpoint's transfers.
// - The packet buffer manager serves an endpoint only while its enable bit is one and leaves it alone otherwise.
// - The X base entry holds address bits 10 to 3 and three zero bits are appended for the 11-bit start.
// - The Y base entry is encoded the same way and gives the start of the second buffer.
// - The base entry is the start address of a transaction and is never changed by the hardware.
// - Count bits 6 to 0 give the packet length in bytes, zero for empty up to 64.
// - Count bit 7 is a NAK flag: clear means free for an OUT packet, set means full and OUT is answered NAK.
`ifndef OUT_EP_REGS_VH
`define OUT_EP_REGS_VH
`define EDB_REGION_TAG  11'h7F8
`define EDB_OFS_CFG     3'h0
`define EDB_OFS_XBASE   3'h1
`define EDB_OFS_XCOUNT  3'h2
`define EDB_OFS_YBASE   3'h5
`define EDB_OFS_YCOUNT  3'h6
`define CFG_IRQ_EN_BIT  2
`define CFG_STALL_BIT   3
`define CFG_DOUBLE_BUFFER_ENABLE_BIT    4
`define CFG_TOGGLE_BIT  5
`define CFG_ISO_BIT     6
`define CFG_BME_BIT     7
`define CFG_RSV_MASK    8'hFC
`define CNT_NAK_BIT     7
`define CNT_MAX_BYTES   7'h40
`define CFG_RESET       8'h00
`define ENTRY_RESET     8'h00
`define HS_ACK          2'h1
`define HS_NAK          2'h2
`define HS_STALL        2'h3
`endif

// [rtl/pair_buffer.v]
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module pair_buffer #(
  parameter WIDTH = 19
) (
  input  wire             i_core_clk,
  input  wire             i_srst,
  input  wire             i_in_valid,
  input  wire [WIDTH-1:0] i_in_data,
  output reg              o_in_ready,
  output reg              o_out_valid,
  output reg  [WIDTH-1:0] o_out_data,
  input  wire             i_out_ready,
  output reg              o_empty
);
  reg  [WIDTH-1:0] spare_q;
  reg              spare_v_q;
  wire             take = i_in_valid & o_in_ready;
  wire             give = o_out_valid & i_out_ready;
  // head register drives the outputs, spare catches a word during a stall
  always @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      o_out_valid <= 1'b0;
      o_out_data  <= {WIDTH{1'b0}};
      spare_q     <= {WIDTH{1'b0}};
      spare_v_q   <= 1'b0;
      o_in_ready  <= 1'b1;
      o_empty     <= 1'b1;
    end
    else
    begin
      if (!o_out_valid || give)
      begin
        o_out_valid <= spare_v_q | take;
        if (spare_v_q)
          o_out_data <= spare_q;
        else if (take)
          o_out_data <= i_in_data;
        if (spare_v_q && take)
          spare_q <= i_in_data;
        spare_v_q <= spare_v_q & take;
      end
      else if (take)
      begin
        spare_q   <= i_in_data;
        spare_v_q <= 1'b1;
      end
      // ready is registered, so it is computed from the next fill level
      o_in_ready <= !(((o_out_valid && !give) || spare_v_q || take) && (spare_v_q || (take && o_out_valid && !give)));
      o_empty    <= !((spare_v_q | take) | (o_out_valid & !give));
    end
  end
endmodule // pair_buffer
`default_nettype wire

// [test/host_model.sv]
// host side model sending out tokens and data packets
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic       i_core_clk,
  input  wire logic       i_rx_ready,
  output var  logic       o_tok_valid,
  output var  logic [1:0] o_tok_ep,
  output var  logic       o_tok_data1,
  output var  logic       o_rx_valid,
  output var  logic [7:0] o_rx_byte,
  output var  logic       o_pkt_end,
  output var  logic       o_pkt_good
);
  initial
    {o_tok_valid, o_tok_ep, o_tok_data1, o_rx_valid, o_rx_byte, o_pkt_end, o_pkt_good} = 15'h0000;
  // released lines show inverted leftovers so nothing passes by luck
  task automatic send(input logic [1:0] ep, input logic d1, input int n, input logic good);
    @(negedge i_core_clk);
    {o_tok_valid, o_tok_ep, o_tok_data1} = {1'b1, ep, d1};
    @(negedge i_core_clk);
    {o_tok_valid, o_tok_ep, o_tok_data1} = {1'b0, ~ep, ~d1};
    for (int k = 0; k < n; k++)
    begin
      {o_rx_valid, o_rx_byte} = {1'b1, 8'hA0 + k[7:0]};
      do @(posedge i_core_clk); while (!i_rx_ready);
      @(negedge i_core_clk);
    end
    {o_rx_valid, o_rx_byte, o_pkt_end, o_pkt_good} = {1'b0, ~o_rx_byte, 1'b1, good};
    @(negedge i_core_clk);
    {o_pkt_end, o_pkt_good} = {1'b0, ~good};
  endtask
endmodule // host_model
`default_nettype wire

// [test/out_ep_chk_sva.sv]
// port checker for the output endpoint descriptor block
`timescale 1ns/1ps
`default_nettype none
`include "out_ep_regs.vh"
module out_ep_chk (
  input wire logic        i_core_clk,
  input wire logic        i_srst,
  input wire logic [15:0] i_xaddr,
  input wire logic        i_xwr,
  input wire logic [7:0]  i_xwdata,
  input wire logic        i_tok_valid,
  input wire logic [1:0]  i_tok_ep,
  input wire logic        i_pkt_end,
  input wire logic        i_pkt_good,
  input wire logic        o_ram_we,
  input wire logic [10:0] o_ram_addr,
  input wire logic        i_ram_ready,
  input wire logic        o_hs_valid,
  input wire logic [1:0]  o_hs_code,
  input wire logic [2:0]  o_irq
);
  // firmware copy of each config; hardware never alters bits 7, 3 and 2
  logic [7:0] cfg_q [0:3];
  wire  [7:0] tc = cfg_q[i_tok_ep];
  wire  [2:0] ie = {cfg_q[3][2], cfg_q[2][2], cfg_q[1][2]};
  wire        tok = i_tok_valid && i_tok_ep != 2'h0;
  always @(posedge i_core_clk)
    if (i_srst)
      cfg_q <= '{default: 8'h00};
    else if (i_xwr && i_xaddr[15:5] == `EDB_REGION_TAG && i_xaddr[2:0] == `EDB_OFS_CFG)
      cfg_q[i_xaddr[4:3]] <= i_xwdata;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_srst);
  AST_IRQ_GATED: assert property (o_irq != 3'h0 |-> (o_irq & ~ie) == 3'h0)
    else $error("irq on endpoint without enable");
  AST_STALL_ANSWER: assert property (tok && tc[7] && tc[3] |-> ##[1:200] o_hs_valid && o_hs_code == `HS_STALL)
    else $error("stalled endpoint gave no stall");
  AST_DISABLED_QUIET: assert property (tok && !tc[7] |=> (!o_hs_valid && !o_ram_we) [*8])
    else $error("disabled endpoint served");
  AST_IRQ_AFTER_ACK: assert property (o_irq != 3'h0 |-> o_hs_code == `HS_ACK)
    else $error("irq without ack");
  AST_BAD_QUIET: assert property (i_pkt_end && !i_pkt_good |=> !o_hs_valid [*4])
    else $error("handshake on bad packet");
  AST_RAM_HOLD: assert property (o_ram_we && !i_ram_ready |=> o_ram_we && $stable(o_ram_addr))
    else $error("ram write dropped under stall");
  AST_RAM_STEP: assert property (o_ram_we && i_ram_ready ##1 o_ram_we |-> o_ram_addr == $past(o_ram_addr) + 11'h001)
    else $error("ram address not sequential");
  AST_HS_PULSE: assert property (o_hs_valid |=> !o_hs_valid)
    else $error("handshake longer than one cycle");
  cover property (o_hs_valid && o_hs_code == `HS_ACK);
  cover property (o_hs_valid && o_hs_code == `HS_NAK);
  cover property (o_hs_valid && o_hs_code == `HS_STALL);
  cover property (o_ram_we && !i_ram_ready);
endmodule // out_ep_chk
bind out_endpoint_descriptor out_ep_chk out_ep_chk_i (.i_core_clk, .i_srst, .i_xaddr, .i_xwr, .i_xwdata,
  .i_tok_valid, .i_tok_ep, .i_pkt_end, .i_pkt_good, .o_ram_we, .o_ram_addr, .i_ram_ready, .o_hs_valid,
  .o_hs_code, .o_irq);
`default_nettype wire

// [test/test_out_endpoint_descriptor.sv]
// self-checking bench for the output endpoint descriptor block
`timescale 1ns/1ps
`default_nettype none
`include "out_ep_regs.vh"
module test_out_endpoint_descriptor;
  logic        i_core_clk, i_srst, i_xwr, i_xrd, i_ram_ready, stall_en, o_rx_ready, o_ram_we, o_hs_valid;
  logic        i_tok_valid, i_tok_data1, i_rx_valid, i_pkt_end, i_pkt_good;
  logic [1:0]  i_tok_ep, o_hs_code, hs_seen = 2'h0;
  logic [7:0]  i_xwdata, o_xrdata, i_rx_byte, o_ram_wdata;
  logic [15:0] i_xaddr;
  logic [10:0] o_ram_addr, ram_first;
  logic [2:0]  o_irq, irq_seen = 3'h0;
  int          err_count = 0, comparisons = 0, cyc = 0, ram_n = 0, ram_wrong = 0;
  out_endpoint_descriptor out_endpoint_descriptor_i (.i_core_clk, .i_srst, .i_xaddr, .i_xwr, .i_xrd,
    .i_xwdata, .o_xrdata, .i_tok_valid, .i_tok_ep, .i_tok_data1, .i_rx_valid, .i_rx_byte, .o_rx_ready,
    .i_pkt_end, .i_pkt_good, .o_ram_we, .o_ram_addr, .o_ram_wdata, .i_ram_ready, .o_hs_valid, .o_hs_code, .o_irq);
  host_model host_model_i (.i_core_clk(i_core_clk), .i_rx_ready(o_rx_ready), .o_tok_valid(i_tok_valid),
    .o_tok_ep(i_tok_ep), .o_tok_data1(i_tok_data1), .o_rx_valid(i_rx_valid), .o_rx_byte(i_rx_byte),
    .o_pkt_end(i_pkt_end), .o_pkt_good(i_pkt_good));
  initial
  begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end
  // ram stalls every other cycle when asked, to exercise the buffer
  always @(negedge i_core_clk)
    i_ram_ready <= !stall_en || cyc[0];
  // ram write log, irq capture and hang guard
  always @(posedge i_core_clk)
  begin
    cyc <= cyc + 1;
    if (o_ram_we && i_ram_ready && ram_n == 0)
      ram_first <= o_ram_addr;
    if (o_ram_we && i_ram_ready)
      ram_n <= ram_n + 1;
    // byte k of a packet carries the host pattern A0 plus k
    if (o_ram_we && i_ram_ready && o_ram_wdata !== 8'hA0 + ram_n[7:0])
      ram_wrong <= ram_wrong + 1;
    // the handshake pulse has fallen long before the hs task checks, so catch it here
    if (o_hs_valid === 1'b1 && hs_seen == 2'h0)
      hs_seen <= o_hs_code;
    irq_seen <= irq_seen | o_irq;
    if (cyc == 20000)
    begin
      err_count++;
      test_done;
    end
  end
  task automatic chk(input string what, input logic [10:0] exp, input logic [10:0] got);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge i_core_clk);
    {i_xaddr, i_xwdata, i_xwr} = {a, d, 1'b1};
    @(negedge i_core_clk);
    i_xwr = 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(negedge i_core_clk);
    {i_xaddr, i_xrd} = {a, 1'b1};
    @(negedge i_core_clk);
    i_xrd = 1'b0;
    @(negedge i_core_clk);
    chk($sformatf("entry %h", a), {3'h0, exp}, {3'h0, o_xrdata});
  endtask
  // first handshake since the packet began, after a bounded wait; code 0 means none may come
  task automatic hs(input logic [1:0] code);
    repeat (150) @(negedge i_core_clk);
    chk("handshake", {9'h000, code}, {9'h000, hs_seen});
  endtask
  task automatic pkt(input logic [1:0] ep, input logic d1, input int n, input logic good);
    ram_n = 0;
    ram_wrong = 0;
    irq_seen = 3'h0;
    hs_seen = 2'h0;
    host_model_i.send(ep, d1, n, good);
  endtask
  task automatic t_reset;
    rd(16'hFF08, 8'h00);
    wr(16'hFF0B, 8'h55);
    rd(16'hFF0B, 8'h00);
    $display("reset test done");
  endtask
  task automatic t_store;
    wr(16'hFF08, 8'h84);
    wr(16'hFF09, 8'h10);
    wr(16'hFF0A, 8'h00);
    stall_en = 1'b1;
    pkt(2'h1, 1'b0, 64, 1'b1);
    hs(`HS_ACK);
    chk("ram start", 11'h080, ram_first);
    chk("ram bytes", 11'h040, ram_n[10:0]);
    chk("ram data errors", 11'h000, ram_wrong[10:0]);
    chk("irq", 11'h001, {8'h00, irq_seen});
    rd(16'hFF0A, 8'hC0);
    rd(16'hFF08, 8'hA4);
    rd(16'hFF09, 8'h10);
    stall_en = 1'b0;
    pkt(2'h1, 1'b1, 4, 1'b1);
    hs(`HS_NAK);
    $display("store and nak test done");
  endtask
  task automatic t_double_buffer_enable;
    wr(16'hFF10, 8'hB0);
    wr(16'hFF12, 8'h80);
    wr(16'hFF15, 8'h20);
    wr(16'hFF16, 8'h00);
    pkt(2'h2, 1'b1, 5, 1'b1);
    hs(`HS_ACK);
    chk("ram start", 11'h100, ram_first);
    chk("ram data errors", 11'h000, ram_wrong[10:0]);
    chk("irq", 11'h000, {8'h00, irq_seen});
    rd(16'hFF16, 8'h85);
    rd(16'hFF12, 8'h80);
    rd(16'hFF10, 8'h90);
    // repeated DATA1 after the toggle moved on: answered but not stored
    wr(16'hFF12, 8'h00);
    pkt(2'h2, 1'b1, 2, 1'b1);
    hs(`HS_ACK);
    chk("ram bytes", 11'h000, ram_n[10:0]);
    rd(16'hFF12, 8'h00);
    rd(16'hFF10, 8'h90);
    $display("double buffer test done");
  endtask
  task automatic t_quiet;
    wr(16'hFF18, 8'h80);
    wr(16'hFF1A, 8'h00);
    pkt(2'h3, 1'b0, 3, 1'b0);
    hs(2'h0);
    rd(16'hFF1A, 8'h00);
    wr(16'hFF18, 8'h00);
    pkt(2'h3, 1'b0, 2, 1'b1);
    hs(2'h0);
    chk("ram bytes", 11'h000, ram_n[10:0]);
    wr(16'hFF18, 8'h88);
    pkt(2'h3, 1'b0, 0, 1'b1);
    hs(`HS_STALL);
    rd(16'hFF18, 8'h88);
    $display("quiet and stall test done");
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    {i_srst, i_xwr, i_xrd, i_xaddr, i_xwdata, stall_en, i_ram_ready} = {3'h4, 24'h000000, 2'h1};
    repeat (4) @(negedge i_core_clk);
    i_srst = 1'b0;
    t_reset;
    t_store;
    t_double_buffer_enable;
    t_quiet;
    test_done;
  end
endmodule // test_out_endpoint_descriptor
`default_nettype wire
